// ### common/sml_pkg.sv
// Constants shared by the serial message link
package sml_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned BAUD = 57_600;
    // Clock cycles per bit, rounded down to whole cycles
    localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
    localparam int unsigned HALF_CYC = BIT_CYC / 2;
    localparam int unsigned DATA_BITS = 7;
    localparam int unsigned FRAME_BITS = 10;
    localparam int unsigned MAX_MSG = 255;
    localparam logic [6:0] CH_LF = 7'h0a;
    localparam logic [6:0] CH_CR = 7'h0d;
    localparam logic [6:0] CH_SEMI = 7'h3b;
    localparam logic [6:0] CH_QMARK = 7'h3f;
    localparam logic [6:0] CH_SPACE = 7'h20;
endpackage

// ### logic/sml_resp_mem.sv
// Response character buffer with registered read data
`timescale 1ns/1ps
module sml_resp_mem #(
    parameter int unsigned DEPTH = 256,
    parameter int unsigned AW = 8
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [6:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [6:0] rd_data
);
    logic [6:0] mem [DEPTH];

    // Write port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule

// ### logic/sml_link.sv
// Serial message link: framing, message splitting and response flow
`timescale 1ns/1ps
// Contract
// - Each character carries seven ASCII data bits within a ten bit frame.
// - One start bit before and one stop bit after every character.
// - One odd parity bit over the seven data bits.
// - Message ends on lone LF or on CR followed by LF.
// - Every response ends with CR then LF.
// - Semicolon separates chained strings; device splits there.
// - Command is mnemonic, space, data, terminator; device executes it.
// - Query is mnemonic, question mark, optional data; device answers it.
// - Response starts without deliberate delay after a complete query.
// - Device never transmits unprompted; only answers queries.
// - Link runs fixed 57,600 baud, no flow control or handshaking.
module sml_link #(
    parameter int unsigned MAX_MSG = sml_pkg::MAX_MSG
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rx_pin,
    output logic tx_pin,
    output logic [6:0] str_char,
    output logic str_valid,
    output logic str_end,
    output logic str_query,
    output logic str_drop,
    output logic parity_err,
    output logic overflow_err,
    input wire logic [6:0] resp_char,
    input wire logic resp_we,
    input wire logic resp_go,
    output logic resp_busy
);
    typedef enum logic [1:0] {
        SML_IDLE = 2'b00, SML_START = 2'b01,
        SML_BITS = 2'b10, SML_STOP = 2'b11
    } sml_ser_t;

    // -------------------------------------------------------------
    // Input synchroniser
    // -------------------------------------------------------------
    logic rx_m_q, rx_s_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
        end else begin
            rx_m_q <= rx_pin;
            rx_s_q <= rx_m_q;
        end
    end

    // -------------------------------------------------------------
    // Receiver: start, 7 data, parity, stop at fixed baud
    // -------------------------------------------------------------
    sml_ser_t rx_st_q;
    logic [15:0] rx_cnt_q;
    logic [3:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    logic rx_done;
    logic rx_perr;
    logic [6:0] rx_char;
    assign rx_char = rx_sh_q[6:0];
    // Odd parity: data plus parity must hold an odd count of ones
    assign rx_perr = ~(^rx_sh_q);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_st_q <= SML_IDLE;
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            case (rx_st_q)
                SML_IDLE: begin
                    rx_cnt_q <= 16'h0000;
                    if (!rx_s_q) begin
                        rx_st_q <= SML_START;
                    end
                end
                SML_START: begin
                    if (rx_cnt_q == 16'(sml_pkg::HALF_CYC)) begin
                        rx_cnt_q <= 16'h0000;
                        rx_bit_q <= 4'h0;
                        rx_st_q <= rx_s_q ? SML_IDLE : SML_BITS;
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 16'h0001;
                    end
                end
                SML_BITS: begin
                    if (rx_cnt_q == 16'(sml_pkg::BIT_CYC - 1)) begin
                        rx_cnt_q <= 16'h0000;
                        // LSB first: 7 data bits then parity
                        rx_sh_q <= {rx_s_q, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_bit_q == 4'(sml_pkg::DATA_BITS)) begin
                            rx_st_q <= SML_STOP;
                        end
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 16'h0001;
                    end
                end
                SML_STOP: begin
                    if (rx_cnt_q == 16'(sml_pkg::BIT_CYC - 1)) begin
                        rx_st_q <= SML_IDLE;
                        rx_done <= 1'b1;
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 16'h0001;
                    end
                end
                default: rx_st_q <= SML_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------
    // Message parser: split at semicolon and terminator
    // -------------------------------------------------------------
    logic bad_q;      // Current transmission holds a non-CR parity error
    logic query_q;    // Current string carries a question mark
    logic [8:0] len_q;
    logic is_term, is_semi;
    assign is_term = rx_done && (rx_char == sml_pkg::CH_LF);
    assign is_semi = rx_done && (rx_char == sml_pkg::CH_SEMI);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bad_q <= 1'b0;
            query_q <= 1'b0;
            len_q <= 9'h000;
            str_char <= 7'h00;
            str_valid <= 1'b0;
            str_end <= 1'b0;
            str_query <= 1'b0;
            str_drop <= 1'b0;
            parity_err <= 1'b0;
            overflow_err <= 1'b0;
        end else begin
            str_valid <= 1'b0;
            str_end <= 1'b0;
            str_drop <= 1'b0;
            parity_err <= 1'b0;
            overflow_err <= 1'b0;
            if (rx_done) begin
                if (rx_perr) begin
                    parity_err <= 1'b1;
                end
                if (len_q == 9'(MAX_MSG)) begin
                    overflow_err <= 1'b1;
                end
                len_q <= is_term ? 9'h000 : len_q + 9'h001;
                if (rx_char == sml_pkg::CH_QMARK) begin
                    query_q <= 1'b1;
                end
                if (is_term || is_semi) begin
                    // Close one string; it is dropped once its transmission holds a non-CR parity error
                    str_end <= ~(bad_q | rx_perr);
                    str_drop <= bad_q | rx_perr;
                    str_query <= query_q;
                    query_q <= 1'b0;
                    if (is_term) begin
                        bad_q <= 1'b0;
                    end else begin
                        bad_q <= bad_q | rx_perr;
                    end
                end else if (rx_char != sml_pkg::CH_CR) begin
                    // CR is swallowed so CR LF and LF end alike
                    str_char <= rx_char;
                    str_valid <= ~rx_perr;
                    bad_q <= bad_q | rx_perr;
                end
            end
        end
    end

    // -------------------------------------------------------------
    // Response buffer and arming by query
    // -------------------------------------------------------------
    logic [7:0] wr_ptr_q, rd_ptr_q;
    logic [6:0] mem_q;
    logic armed_q;
    sml_resp_mem #(.DEPTH(256), .AW(8)) sml_resp_mem_i (
        .clk(clk),
        .wr_en(resp_we && !resp_busy && armed_q),
        .wr_addr(wr_ptr_q),
        .wr_data(resp_char),
        .rd_addr(rd_ptr_q),
        .rd_data(mem_q)
    );

    // -------------------------------------------------------------
    // Transmitter: body, then CR LF, only after a query
    // -------------------------------------------------------------
    sml_ser_t tx_st_q;
    logic [15:0] tx_cnt_q;
    logic [3:0] tx_bit_q;
    logic [7:0] tx_sh_q;
    logic [1:0] tail_q;  // 0 body, 1 CR sent next, 2 LF next, 3 done
    logic tx_run_q;
    logic load;
    logic [6:0] nxt;
    assign resp_busy = tx_run_q;
    assign nxt = (tail_q == 2'd1) ? sml_pkg::CH_CR :
                 (tail_q == 2'd2) ? sml_pkg::CH_LF : mem_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            armed_q <= 1'b0;
            wr_ptr_q <= 8'h00;
        end else if (str_end && str_query) begin
            armed_q <= 1'b1;
            wr_ptr_q <= 8'h00;
        end else if (resp_go && armed_q && !tx_run_q) begin
            armed_q <= 1'b0;
        end else if (resp_we && armed_q && !tx_run_q) begin
            wr_ptr_q <= wr_ptr_q + 8'h01;
        end
    end

    assign load = (tx_st_q == SML_IDLE) && tx_run_q && (tail_q != 2'd3);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_st_q <= SML_IDLE;
            tx_cnt_q <= 16'h0000;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 8'hff;
            tail_q <= 2'd0;
            tx_run_q <= 1'b0;
            rd_ptr_q <= 8'h00;
            tx_pin <= 1'b1;
        end else begin
            case (tx_st_q)
                SML_IDLE: begin
                    tx_pin <= 1'b1;
                    if (resp_go && armed_q && !tx_run_q) begin
                        // Start at once, no added delay
                        tx_run_q <= 1'b1;
                        tail_q <= (wr_ptr_q == 8'h00) ? 2'd1 : 2'd0;
                    end else if (tx_run_q && tail_q == 2'd3) begin
                        tx_run_q <= 1'b0;
                        rd_ptr_q <= 8'h00; // Rewind ahead of registered read
                    end else if (load) begin
                        tx_sh_q <= {~(^nxt), nxt};
                        tx_st_q <= SML_START;
                        tx_cnt_q <= 16'h0000;
                        if (tail_q == 2'd0) begin
                            rd_ptr_q <= rd_ptr_q + 8'h01;
                            if (rd_ptr_q + 8'h01 == wr_ptr_q) begin
                                tail_q <= 2'd1;
                            end
                        end else begin
                            tail_q <= tail_q + 2'd1;
                        end
                    end
                end
                SML_START: begin
                    tx_pin <= 1'b0;
                    if (tx_cnt_q == 16'(sml_pkg::BIT_CYC - 1)) begin
                        tx_cnt_q <= 16'h0000;
                        tx_bit_q <= 4'h0;
                        tx_st_q <= SML_BITS;
                    end else begin
                        tx_cnt_q <= tx_cnt_q + 16'h0001;
                    end
                end
                SML_BITS: begin
                    tx_pin <= tx_sh_q[0];
                    if (tx_cnt_q == 16'(sml_pkg::BIT_CYC - 1)) begin
                        tx_cnt_q <= 16'h0000;
                        tx_sh_q <= {1'b1, tx_sh_q[7:1]};
                        tx_bit_q <= tx_bit_q + 4'h1;
                        if (tx_bit_q == 4'(sml_pkg::DATA_BITS)) begin
                            tx_st_q <= SML_STOP;
                        end
                    end else begin
                        tx_cnt_q <= tx_cnt_q + 16'h0001;
                    end
                end
                SML_STOP: begin
                    tx_pin <= 1'b1; // Load cycle completes the bit
                    if (tx_cnt_q == 16'(sml_pkg::BIT_CYC - 2)) begin
                        tx_st_q <= SML_IDLE;
                    end else begin
                        tx_cnt_q <= tx_cnt_q + 16'h0001;
                    end
                end
                default: tx_st_q <= SML_IDLE;
            endcase
        end
    end
endmodule

// ### verification/sml_link_chk.sv
// Port checker for the serial message link
`timescale 1ns/1ps
module sml_link_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tx_pin,
    input wire logic [6:0] str_char,
    input wire logic str_valid,
    input wire logic str_end,
    input wire logic str_query,
    input wire logic str_drop,
    input wire logic resp_go,
    input wire logic resp_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic tx_q, run_on_q, qseen_q;
    int unsigned run_q;
    // Length of each tx level run inside a reply
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_q <= 1'b1;
            run_q <= 0;
            run_on_q <= 1'b0;
        end else begin
            tx_q <= tx_pin;
            run_q <= (tx_pin != tx_q) ? 1 : run_q + 1;
            run_on_q <= resp_busy && (run_on_q || tx_pin != tx_q);
        end
    end
    // Question mark seen in the open string
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            qseen_q <= 1'b0;
        else if (str_end || str_drop)
            qseen_q <= 1'b0;
        else if (str_valid && str_char == sml_pkg::CH_QMARK)
            qseen_q <= 1'b1;
    end
    sequence reply_done_s;
        $fell(resp_busy) ##0 $past(tx_pin);
    endsequence
    idle_high_a: assert property (!resp_busy |-> tx_pin)
        else $error("tx active outside a reply");
    busy_cause_a: assert property (
        $rose(resp_busy) |-> $past(resp_go) || $past(resp_go, 2))
        else $error("reply started without go");
    stop_high_a: assert property (reply_done_s |-> tx_pin)
        else $error("reply did not end on stop level");
    bit_width_a: assert property (
        run_on_q && tx_pin != tx_q |-> run_q % sml_pkg::BIT_CYC == 0)
        else $error("tx bit length wrong");
    char_filter_a: assert property (
        str_valid |-> !(str_char inside {7'h0a, 7'h0d, 7'h3b}))
        else $error("delimiter passed as string char");
    end_drop_a: assert property (!(str_end && str_drop))
        else $error("end and drop together");
    query_flag_a: assert property (str_end |-> str_query == qseen_q)
        else $error("query flag wrong");
    single_end_a: assert property (str_end |=> !str_end)
        else $error("string end longer than a cycle");
endmodule
bind sml_link sml_link_chk sml_link_chk_i (.clk(clk), .sys_rst(sys_rst),
    .tx_pin(tx_pin), .str_char(str_char), .str_valid(str_valid),
    .str_end(str_end), .str_query(str_query), .str_drop(str_drop),
    .resp_go(resp_go), .resp_busy(resp_busy));

// ### verification/sml_host_model.sv
// Host program model: frames characters and reads replies
`timescale 1ns/1ps
module sml_host_model (
    input wire logic clk,
    input wire logic tx_pin,
    output logic rx_pin
);
    localparam int unsigned BC = sml_pkg::BIT_CYC;
    // Quiet gap, shortened from 50 ms to keep the run short
    localparam int unsigned GAP = 2000;
    initial rx_pin = 1'b1;
    // One frame: start, data LSB first, odd parity, stop
    task automatic send_char(logic [6:0] c, bit bad);
        logic [9:0] f;
        f = {1'b1, ~^c ^ bad, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rx_pin <= f[i];
            repeat (BC - 1) @(posedge clk);
        end
    endtask
    // Whole string back to back, terminator included
    task automatic send_str(string s);
        logic [7:0] b;
        for (int i = 0; i < s.len(); i++) begin
            b = s[i];
            send_char(b[6:0], 1'b0);
        end
    endtask
    // Hold off new traffic after a transfer
    task automatic quiet;
        repeat (GAP) @(posedge clk);
    endtask
    // Wait for a start bit, then sample each bit mid-way
    task automatic recv_char(int lim, output logic [6:0] c, output bit ok);
        logic [9:0] f;
        int n;
        n = 0;
        while (tx_pin === 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        repeat (BC / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            f[i] = tx_pin;
            repeat (i < 9 ? BC : 0) @(posedge clk);
        end
        c = f[7:1];
        ok = n < lim && f[0] === 1'b0 && f[9] === 1'b1 && ^f[8:1] === 1'b1;
    endtask
endmodule

// ### verification/serial_message_link_tb.sv
// Self-checking bench for the serial message link
`timescale 1ns/1ps
module serial_message_link_tb;
    logic clk, sys_rst, rx_pin, tx_pin, str_valid, str_end, str_query;
    logic str_drop, parity_err, overflow_err, resp_we, resp_go, resp_busy;
    logic [6:0] str_char, resp_char;
    logic [6:0] got[$];
    int ends, drops, qends, perrs, ovfs, miscompares, checks_done;
    // Short length limit so an overflow fits in a short run
    localparam int unsigned MSG_LIM = 8;
    sml_link #(.MAX_MSG(MSG_LIM)) sml_link_i (.clk(clk), .sys_rst(sys_rst),
        .rx_pin(rx_pin),
        .tx_pin(tx_pin), .str_char(str_char), .str_valid(str_valid),
        .str_end(str_end), .str_query(str_query), .str_drop(str_drop),
        .parity_err(parity_err), .overflow_err(overflow_err),
        .resp_char(resp_char), .resp_we(resp_we), .resp_go(resp_go),
        .resp_busy(resp_busy));
    sml_host_model sml_host_model_i (.clk(clk), .tx_pin(tx_pin),
        .rx_pin(rx_pin));
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Count string events
    always @(posedge clk) begin
        if (str_valid === 1'b1) got.push_back(str_char);
        ends += (str_end === 1'b1);
        qends += (str_end === 1'b1 && str_query === 1'b1);
        drops += (str_drop === 1'b1);
        perrs += (parity_err === 1'b1);
        ovfs += (overflow_err === 1'b1);
    end
    // Compare one value
    task automatic check(logic [31:0] seen, logic [31:0] exp, string m);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s %0h/%0h", $time, m, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("%0d checks, %0d mismatches", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Query ended by CR LF, then a two character reply
    task automatic t_query;
        logic [6:0] want[4] = '{7'h58, 7'h59, 7'h0d, 7'h0a};
        logic [6:0] c;
        bit ok;
        sml_host_model_i.send_str("AB?\015\n");
        for (int n = 0; n < 400 && qends == 0; n++) @(posedge clk);
        check(qends, 1, "query end");
        check(got.size(), 3, "chars");
        check(got[2], 7'h3f, "mark");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            resp_char <= want[i];
            resp_we <= (i < 2);
            resp_go <= (i == 2);
        end
        @(posedge clk);
        resp_go <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            sml_host_model_i.recv_char(i == 0 ? 6 : 400, c, ok);
            check(ok, 1, "frame");
            check(c, want[i], "reply");
            if (!ok) final_report();
        end
        sml_host_model_i.quiet();
        check(resp_busy, 0, "busy");
    endtask
    // Chained commands; go without a query stays silent
    task automatic t_chain;
        got.delete();
        sml_host_model_i.send_str("C 1;D\n");
        sml_host_model_i.quiet();
        check(ends, 3, "ends");
        check(got.size(), 4, "chars");
        check(got[1], 7'h20, "space");
        check(qends, 1, "no query");
        resp_go <= 1'b1;
        @(posedge clk);
        resp_go <= 1'b0;
        repeat (9) @(posedge clk);
        check({tx_pin, resp_busy}, 2'h2, "silent");
    endtask
    // Bad parity discards the message
    task automatic t_parity;
        sml_host_model_i.send_char(7'h45, 1'b1);
        sml_host_model_i.send_char(7'h0a, 1'b0);
        sml_host_model_i.quiet();
        check(perrs, 1, "parity");
        check(drops, 1, "drop");
        check(ends, 3, "no run");
    endtask
    // Query past the length limit, then a second, one character reply
    task automatic t_long;
        logic [6:0] want[3] = '{7'h5a, 7'h0d, 7'h0a};
        logic [6:0] c;
        bit ok;
        sml_host_model_i.send_str("ABCDEFGH?\n");
        for (int n = 0; n < 400 && qends == 1; n++) @(posedge clk);
        check(ovfs, 1, "overflow");
        check(qends, 2, "query end");
        resp_char <= want[0];
        resp_we <= 1'b1;
        @(posedge clk);
        resp_we <= 1'b0;
        resp_go <= 1'b1;
        @(posedge clk);
        resp_go <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            sml_host_model_i.recv_char(i == 0 ? 6 : 400, c, ok);
            check(ok, 1, "frame");
            check(c, want[i], "reply");
        end
        sml_host_model_i.quiet();
        check(resp_busy, 0, "busy");
    endtask
    initial begin
        sys_rst = 1'b1;
        resp_char = 7'h00;
        resp_we = 1'b0;
        resp_go = 1'b0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_query();
        t_chain();
        t_parity();
        t_long();
        final_report();
    end
endmodule
